// *** hdl/ced_cfg.svh ***
`ifndef CED_CFG_SVH
`define CED_CFG_SVH

// Stack step and vector scaling.
`define CED_SP_STEP        32'h0000_0004
`define CED_VEC_SHIFT      2

// Interrupt mask field position inside the status word.
`define CED_MASK_LSB       4
`define CED_MASK_MSB       7

// Priority levels.
`define CED_NMI_LEVEL      5'h10
`define CED_NMI_MASK       4'hF
`define CED_FIXED_LEVEL    4'hF

// Access sizes of a data cycle.
`define CED_SIZE_WORD      2'h1
`define CED_SIZE_LONG      2'h2

// Lowest opcode of the guaranteed undefined range.
`define CED_ILL_LOW        16'hFC00

// Fixed interrupt vector numbers.
`define CED_VEC_NMI        8'h0B
`define CED_VEC_BREAK      8'h0C
`define CED_VEC_DEBUG      8'h0D
`define CED_VEC_EXT_LO     8'h40
`define CED_VEC_EXT_HI     8'h50

`endif

// *** hdl/ced_exc_entry.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ced_cfg.svh"

module ced_exc_entry #(
    parameter logic [7:0] VEC_GEN_ILL  = 8'h01,
    parameter logic [7:0] VEC_SLOT_ILL = 8'h02,
    parameter logic [7:0] VEC_ADDR_ERR = 8'h03,
    parameter int         N_EXT        = 8,
    parameter int         N_PERIPH     = 18
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    fetch_valid,
    input  wire logic [31:0]             fetch_addr,
    input  wire logic                    data_valid,
    input  wire logic [1:0]              data_size,
    input  wire logic [31:0]             data_addr,
    input  wire logic [31:0]             acc_instr_addr,
    input  wire logic                    acc_in_slot,
    input  wire logic [31:0]             acc_branch_addr,
    input  wire logic                    dec_valid,
    input  wire logic [15:0]             dec_opcode,
    input  wire logic                    dec_flow_change,
    input  wire logic                    dec_in_slot,
    input  wire logic [31:0]             dec_addr,
    input  wire logic [31:0]             dec_slot_target,
    input  wire logic                    trap_exec,
    input  wire logic [31:0]             trap_next_pc,
    input  wire logic                    instr_boundary,
    input  wire logic [31:0]             status_word,
    input  wire logic [31:0]             vector_base_register,
    input  wire logic [31:0]             stack_pointer,
    input  wire logic                    nmi_pin,
    input  wire logic [N_EXT-1:0]        external_request_pins,
    input  wire logic [N_EXT*4-1:0]      ext_level,
    input  wire logic                    break_controller_req,
    input  wire logic                    debug_interface_req,
    input  wire logic [N_PERIPH-1:0]     periph_req,
    input  wire logic [N_PERIPH*4-1:0]   periph_level,
    input  wire logic [N_PERIPH*8-1:0]   periph_vector,
    input  wire logic                    mem_ack,
    input  wire logic [31:0]             mem_rdata,
    output logic                         busy,
    output logic                         mem_req,
    output logic                         mem_we,
    output logic [31:0]                  mem_addr,
    output logic [31:0]                  mem_wdata,
    output logic                         sp_we,
    output logic [31:0]                  sp_value,
    output logic                         mask_we,
    output logic [3:0]                   mask_value,
    output logic                         pc_load,
    output logic [31:0]                  pc_value,
    output logic                         int_ack,
    output logic [7:0]                   int_ack_vector
);
    import ced_pkg::*;

    localparam int NS = N_EXT + N_PERIPH + 2;

    function automatic logic misaligned(input logic [31:0] a, input logic [1:0] sz);
        misaligned = (sz == `CED_SIZE_WORD && a[0]) ||
                     (sz == `CED_SIZE_LONG && a[1:0] != 2'h0);
    endfunction

    // Pins cross in through two flip-flops; NMI is edge triggered off stage two.
    logic [N_EXT-1:0] ext_s1, ext_s2;
    logic             nmi_s1, nmi_s2, nmi_s3;

    logic [NS-1:0]    src_req;
    logic [NS*4-1:0]  src_level;
    logic [NS*8-1:0]  src_vector;
    logic [N_EXT*8-1:0] ext_vector;

    genvar g;
    generate
        for (g = 0; g < N_EXT; g++) begin : g_ext
            assign ext_vector[g*8 +: 8] = (g < 4) ? `CED_VEC_EXT_LO + 8'(g)
                                                  : `CED_VEC_EXT_HI + 8'(g - 4);
        end
    endgenerate

    // Break and debug carry fixed level 15; the rest use their programmed
    // 4-bit level, which by width alone can never reach 16.
    assign src_req    = {periph_req, ext_s2, debug_interface_req, break_controller_req};
    assign src_level  = {periph_level, ext_level, `CED_FIXED_LEVEL, `CED_FIXED_LEVEL};
    assign src_vector = {periph_vector, ext_vector, `CED_VEC_DEBUG, `CED_VEC_BREAK};

    logic       sel_valid;
    logic [3:0] sel_level;
    logic [7:0] sel_vector;

    ced_prio_sel #(.N(NS), .LW(4), .VW(8)) u_prio (
        .clk        (clk),
        .reset_n    (reset_n),
        .req        (src_req),
        .level      (src_level),
        .vector     (src_vector),
        .sel_valid  (sel_valid),
        .sel_level  (sel_level),
        .sel_vector (sel_vector)
    );

    ced_state_t state, next_state;
    ced_src_t   src, next_src;
    logic        ae_pend, next_ae_pend;
    logic [31:0] ae_pc, next_ae_pc;
    logic        si_pend, next_si_pend;
    logic [31:0] si_pc, next_si_pc;
    logic        gi_pend, next_gi_pend;
    logic [31:0] gi_pc, next_gi_pc;
    logic        tr_pend, next_tr_pend;
    logic [31:0] tr_pc, next_tr_pc;
    logic [7:0]  tr_vec, next_tr_vec;
    logic        nmi_pend, next_nmi_pend;
    logic [31:0] save_pc, next_save_pc;
    logic [7:0]  vec, next_vec;
    logic [4:0]  acc_level, next_acc_level;
    logic [31:0] sp_work, next_sp_work;
    logic        next_busy, next_mem_req, next_mem_we, next_sp_we, next_mask_we;
    logic        next_pc_load, next_int_ack;
    logic [31:0] next_mem_addr, next_mem_wdata, next_sp_value, next_pc_value;
    logic [3:0]  next_mask_value;
    logic [7:0]  next_int_ack_vector;

    logic [3:0] mask_field;
    logic       ae_set, si_set, gi_set, undef, int_ok, start;

    assign mask_field = status_word[`CED_MASK_MSB:`CED_MASK_LSB];
    // Detection is promised only for the top opcode block.
    assign undef  = dec_opcode >= `CED_ILL_LOW;
    assign ae_set = (fetch_valid && fetch_addr[0]) ||
                    (data_valid && misaligned(data_addr, data_size));
    assign si_set = dec_valid && dec_in_slot && (undef || dec_flow_change);
    assign gi_set = dec_valid && !dec_in_slot && undef;
    // NMI ignores the mask; all else must beat it strictly.
    assign int_ok = nmi_pend || (sel_valid && sel_level > mask_field);
    // Entry only at an instruction boundary, so the faulting bus cycle and
    // instruction are left to finish first.
    assign start  = state == st_idle && instr_boundary &&
                    (ae_pend || si_pend || gi_pend || tr_pend || int_ok);

    always_comb begin
        next_state = state;
        next_src = src;
        next_save_pc = save_pc;
        next_vec = vec;
        next_acc_level = acc_level;
        next_sp_work = sp_work;
        next_busy = state != st_idle;
        next_mem_req = mem_req;
        next_mem_we = mem_we;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_sp_we = 1'b0;
        next_sp_value = sp_value;
        next_mask_we = 1'b0;
        next_mask_value = mask_value;
        next_pc_load = 1'b0;
        next_pc_value = pc_value;
        next_int_ack = 1'b0;
        next_int_ack_vector = int_ack_vector;
        next_ae_pc = ae_pc;
        next_si_pc = si_pc;
        next_gi_pc = gi_pc;
        next_tr_pc = tr_pc;
        next_tr_vec = tr_vec;
        // A new event in the clearing cycle survives: set wins.
        next_ae_pend = ae_pend;
        next_si_pend = si_pend;
        next_gi_pend = gi_pend;
        next_tr_pend = tr_pend;
        next_nmi_pend = nmi_pend;
        case (state)
            st_idle: begin
                if (start) begin
                    next_state = st_push_sr;
                    next_busy = 1'b1;
                    next_acc_level = 5'h00;
                    if (ae_pend) begin
                        next_src = src_addr_err;
                        next_save_pc = ae_pc;
                        next_vec = VEC_ADDR_ERR;
                        next_ae_pend = 1'b0;
                    end else if (si_pend) begin
                        next_src = src_slot_ill;
                        next_save_pc = si_pc;
                        next_vec = VEC_SLOT_ILL;
                        next_si_pend = 1'b0;
                    end else if (gi_pend) begin
                        next_src = src_gen_ill;
                        next_save_pc = gi_pc;
                        next_vec = VEC_GEN_ILL;
                        next_gi_pend = 1'b0;
                    end else if (tr_pend) begin
                        next_src = src_trap;
                        next_save_pc = tr_pc;
                        next_vec = tr_vec;
                        next_tr_pend = 1'b0;
                    end else begin
                        next_src = src_int;
                        next_save_pc = acc_instr_addr;
                        next_int_ack = 1'b1;
                        if (nmi_pend) begin
                            next_vec = `CED_VEC_NMI;
                            next_acc_level = `CED_NMI_LEVEL;
                            next_nmi_pend = 1'b0;
                        end else begin
                            next_vec = sel_vector;
                            next_acc_level = {1'b0, sel_level};
                        end
                        next_int_ack_vector = next_vec;
                    end
                    // Status word goes first.
                    next_sp_work = stack_pointer - `CED_SP_STEP;
                    next_mem_req = 1'b1;
                    next_mem_we = 1'b1;
                    next_mem_addr = stack_pointer - `CED_SP_STEP;
                    next_mem_wdata = status_word;
                end
            end
            st_push_sr: begin
                if (mem_ack) begin
                    next_state = st_push_pc;
                    next_sp_work = sp_work - `CED_SP_STEP;
                    next_mem_addr = sp_work - `CED_SP_STEP;
                    next_mem_wdata = save_pc;
                end
            end
            st_push_pc: begin
                if (mem_ack) begin
                    next_state = st_fetch_vec;
                    next_mem_we = 1'b0;
                    next_mem_wdata = 32'h0000_0000;
                    next_mem_addr = vector_base_register +
                                    {22'h0, vec, 2'h0};
                end
            end
            st_fetch_vec: begin
                if (mem_ack) begin
                    next_state = st_branch;
                    next_mem_req = 1'b0;
                    next_pc_load = 1'b1;
                    next_pc_value = mem_rdata;
                    next_sp_we = 1'b1;
                    next_sp_value = sp_work;
                    if (src == src_int) begin
                        next_mask_we = 1'b1;
                        next_mask_value = acc_level[4] ? `CED_NMI_MASK : acc_level[3:0];
                    end
                end
            end
            st_branch: begin
                next_state = st_idle;
                next_busy = 1'b0;
            end
            default: next_state = st_idle;
        endcase
        // An event in the cycle that clears its flag captures its own address,
        // so the next entry never stacks the address of the one just taken.
        // An address error in a delay slot stacks the branch address.
        if (ae_set && !next_ae_pend) begin
            next_ae_pend = 1'b1;
            next_ae_pc = acc_in_slot ? acc_branch_addr : acc_instr_addr;
        end
        if (si_set && !next_si_pend) begin
            next_si_pend = 1'b1;
            next_si_pc = dec_slot_target;
        end
        if (gi_set && !next_gi_pend) begin
            next_gi_pend = 1'b1;
            next_gi_pc = dec_addr;
        end
        if (trap_exec && !next_tr_pend) begin
            next_tr_pend = 1'b1;
            next_tr_pc = trap_next_pc;
            next_tr_vec = dec_opcode[7:0];
        end
        if (nmi_s2 && !nmi_s3) next_nmi_pend = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ext_s1 <= '0;
            ext_s2 <= '0;
            nmi_s1 <= 1'b0;
            nmi_s2 <= 1'b0;
            nmi_s3 <= 1'b0;
            state <= st_idle;
            src <= src_addr_err;
            ae_pend <= 1'b0;
            ae_pc <= 32'h0000_0000;
            si_pend <= 1'b0;
            si_pc <= 32'h0000_0000;
            gi_pend <= 1'b0;
            gi_pc <= 32'h0000_0000;
            tr_pend <= 1'b0;
            tr_pc <= 32'h0000_0000;
            tr_vec <= 8'h00;
            nmi_pend <= 1'b0;
            save_pc <= 32'h0000_0000;
            vec <= 8'h00;
            acc_level <= 5'h00;
            sp_work <= 32'h0000_0000;
            busy <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            sp_we <= 1'b0;
            sp_value <= 32'h0000_0000;
            mask_we <= 1'b0;
            mask_value <= 4'h0;
            pc_load <= 1'b0;
            pc_value <= 32'h0000_0000;
            int_ack <= 1'b0;
            int_ack_vector <= 8'h00;
        end else begin
            ext_s1 <= external_request_pins;
            ext_s2 <= ext_s1;
            nmi_s1 <= nmi_pin;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
            state <= next_state;
            src <= next_src;
            ae_pend <= next_ae_pend;
            ae_pc <= next_ae_pc;
            si_pend <= next_si_pend;
            si_pc <= next_si_pc;
            gi_pend <= next_gi_pend;
            gi_pc <= next_gi_pc;
            tr_pend <= next_tr_pend;
            tr_pc <= next_tr_pc;
            tr_vec <= next_tr_vec;
            nmi_pend <= next_nmi_pend;
            save_pc <= next_save_pc;
            vec <= next_vec;
            acc_level <= next_acc_level;
            sp_work <= next_sp_work;
            busy <= next_busy;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            sp_we <= next_sp_we;
            sp_value <= next_sp_value;
            mask_we <= next_mask_we;
            mask_value <= next_mask_value;
            pc_load <= next_pc_load;
            pc_value <= next_pc_value;
            int_ack <= next_int_ack;
            int_ack_vector <= next_int_ack_vector;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence push_sr_done;
        state == st_push_sr && mem_ack;
    endsequence
    sequence push_pc_done;
        state == st_push_pc && mem_ack;
    endsequence

    fetch_odd_a: assert property (fetch_valid && fetch_addr[0] |=> ae_pend)
        else $error("odd fetch did not raise address error");
    word_odd_a: assert property (data_valid && data_size == `CED_SIZE_WORD && data_addr[0]
        |=> ae_pend)
        else $error("odd word access did not raise address error");
    long_misalign_a: assert property (data_valid && data_size == `CED_SIZE_LONG &&
        data_addr[1:0] != 2'h0 |=> ae_pend)
        else $error("misaligned longword did not raise address error");
    entry_boundary_a: assert property ($rose(state == st_push_sr) |-> $past(instr_boundary))
        else $error("exception entry away from an instruction boundary");
    push_step_a: assert property (push_sr_done |=> state == st_push_pc && mem_we &&
        mem_addr == $past(mem_addr) - `CED_SP_STEP && mem_wdata == save_pc)
        else $error("second push has wrong address or data");
    vector_addr_a: assert property (push_pc_done |=> !mem_we &&
        mem_addr == vector_base_register + {22'h0, vec, 2'h0})
        else $error("vector fetch address wrong");
    branch_load_a: assert property (state == st_fetch_vec && mem_ack |=> pc_load &&
        pc_value == $past(mem_rdata) ##1 !pc_load)
        else $error("handler branch not taken from vector");
    nmi_mask_a: assert property (mask_we && acc_level == `CED_NMI_LEVEL |-> mask_value == 4'hF)
        else $error("NMI entry did not set mask to all ones");
    int_level_a: assert property (mask_we && !acc_level[4] |-> mask_value > mask_field)
        else $error("interrupt taken at or below mask");
    nmi_take_a: assert property (state == st_idle && instr_boundary && nmi_pend && !ae_pend &&
        !si_pend && !gi_pend && !tr_pend |=> state == st_push_sr && acc_level == 5'h10)
        else $error("pending NMI not accepted");

endmodule

`default_nettype wire

// *** hdl/ced_pkg.sv ***
package ced_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_push_sr,
        st_push_pc,
        st_fetch_vec,
        st_branch
    } ced_state_t;

    typedef enum logic [2:0] {
        src_addr_err,
        src_slot_ill,
        src_gen_ill,
        src_trap,
        src_int
    } ced_src_t;

endpackage

// *** hdl/ced_prio_sel.sv ***
`timescale 1ns/10ps
`default_nettype none

module ced_prio_sel #(
    parameter int N  = 28,
    parameter int LW = 4,
    parameter int VW = 8
) (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic [N-1:0]    req,
    input  wire logic [N*LW-1:0] level,
    input  wire logic [N*VW-1:0] vector,
    output logic                 sel_valid,
    output logic [LW-1:0]        sel_level,
    output logic [VW-1:0]        sel_vector
);
    logic          next_valid;
    logic [LW-1:0] next_level;
    logic [VW-1:0] next_vector;

    // A later source only wins with a strictly higher level, so ties go to
    // the lowest index and the choice stays stable while requests hold.
    always_comb begin
        next_valid  = 1'b0;
        next_level  = '0;
        next_vector = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i] && (!next_valid || level[i*LW +: LW] > next_level)) begin
                next_valid  = 1'b1;
                next_level  = level[i*LW +: LW];
                next_vector = vector[i*VW +: VW];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_valid  <= 1'b0;
            sel_level  <= '0;
            sel_vector <= '0;
        end else begin
            sel_valid  <= next_valid;
            sel_level  <= next_level;
            sel_vector <= next_vector;
        end
    end

endmodule

`default_nettype wire

// *** testbench/ced_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module ced_mem_model (
    input  wire logic        clk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [1:0]  stall,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    int cnt = 0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    // Read data keeps toggling outside an answer, so a stale word never passes as valid.
    always @(posedge clk) begin
        mem_rdata <= ~mem_rdata;
        if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            cnt <= 0;
        end else if (cnt >= stall) begin
            mem_ack <= 1'b1;
            if (!mem_we) mem_rdata <= ~mem_addr;
        end else cnt <= cnt + 1;
    end
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic clk = 0, reset_n = 0;
    logic fetch_valid, data_valid, dec_valid, dec_flow_change, dec_in_slot, trap_exec;
    logic instr_boundary, nmi_pin, break_controller_req, debug_interface_req, acc_in_slot;
    logic mem_ack, busy, mem_req, mem_we, sp_we, mask_we, pc_load, int_ack;
    logic [1:0] data_size, stall;
    logic [3:0] mask_value, lv;
    logic [7:0] external_request_pins, int_ack_vector;
    logic [15:0] dec_opcode;
    logic [17:0] periph_req;
    logic [31:0] fetch_addr, data_addr, acc_instr_addr, acc_branch_addr, dec_addr, r;
    logic [31:0] dec_slot_target, trap_next_pc, status_word, vector_base_register;
    logic [31:0] stack_pointer, mem_rdata, mem_addr, mem_wdata, sp_value, pc_value, ext_level;
    logic [31:0] seed = 32'hA2D9DF0B;
    logic [71:0] periph_level;
    logic [143:0] periph_vector;
    int fail_count = 0, samples_checked = 0, i;

    ced_exc_entry ced_exc_entry_inst (.clk, .reset_n, .fetch_valid, .fetch_addr, .data_valid,
        .data_size, .data_addr, .acc_instr_addr, .acc_in_slot, .acc_branch_addr, .dec_valid,
        .dec_opcode, .dec_flow_change, .dec_in_slot, .dec_addr, .dec_slot_target, .trap_exec,
        .trap_next_pc, .instr_boundary, .status_word, .vector_base_register, .stack_pointer,
        .nmi_pin, .external_request_pins, .ext_level, .break_controller_req,
        .debug_interface_req, .periph_req, .periph_level, .periph_vector, .mem_ack, .mem_rdata,
        .busy, .mem_req, .mem_we, .mem_addr, .mem_wdata, .sp_we, .sp_value, .mask_we,
        .mask_value, .pc_load, .pc_value, .int_ack, .int_ack_vector);
    ced_mem_model ced_mem_model_inst (.clk, .mem_req, .mem_we, .mem_addr, .stall, .mem_ack,
        .mem_rdata);

    initial forever #5 clk = ~clk;

    function logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic setup(input logic [3:0] mask);
        repeat (4) @(negedge clk);
        stack_pointer = rnd() & 32'hFFFFFFFC;
        vector_base_register = rnd() & 32'h0FFFFFFC;
        status_word = (rnd() & 32'hFFFFFF0F) | {24'h0, mask, 4'h0};
        {acc_instr_addr, acc_branch_addr, dec_addr} = {rnd(), rnd(), rnd()};
        {dec_slot_target, trap_next_pc, r} = {rnd(), rnd(), rnd()};
        stall = r[25:24];
    endtask

    task automatic none();
        @(negedge clk);
        {fetch_valid, data_valid} = '0;
        repeat (10) begin
            @(posedge clk);
            check(busy, 0);
        end
        @(negedge clk);
        {external_request_pins, break_controller_req} = '0;
    endtask

    task automatic hit(input logic [7:0] vec, input logic [31:0] pc, input logic mw,
                       input logic [3:0] mv, input int hold);
        logic [31:0] a[3], d[3], ea;
        logic [7:0] av;
        logic [2:0] wv;
        int k;
        k = 0;
        av = '0;
        @(negedge clk);
        {fetch_valid, data_valid, dec_valid, dec_in_slot, dec_flow_change, trap_exec} = '0;
        acc_in_slot = 0;
        if (hold > 0) begin
            instr_boundary = 0;
            repeat (hold) begin
                @(posedge clk);
                check(busy, 0);
            end
            @(negedge clk);
            instr_boundary = 1;
        end
        repeat (80) begin
            @(posedge clk);
            if (mem_req && mem_ack && k < 3) begin
                a[k] = mem_addr;
                d[k] = mem_wdata;
                wv[2-k] = mem_we;
                k++;
            end
            if (int_ack) av = int_ack_vector;
            if (pc_load) break;
            @(negedge clk);
            if (busy) {nmi_pin, external_request_pins, periph_req} = '0;
            if (busy) {break_controller_req, debug_interface_req} = '0;
        end
        ea = vector_base_register + {22'h0, vec, 2'h0};
        check(a[0], stack_pointer - 32'h4);
        check(d[0], status_word);
        check(a[1], stack_pointer - 32'h8);
        check(d[1], pc);
        check(a[2], ea);
        check({wv, pc_load, sp_we, mask_we}, {5'h1B, mw});
        if (mw) check(mask_value, mv);
        check(pc_value, ~ea);
        check(sp_value, stack_pointer - 32'h8);
        check(av, mw ? vec : 8'h00);
    endtask

    initial begin
        {fetch_valid, data_valid, dec_valid, dec_flow_change, dec_in_slot, trap_exec} = '0;
        {nmi_pin, break_controller_req, debug_interface_req, acc_in_slot, data_size} = '0;
        {stall, dec_opcode, external_request_pins, periph_req, ext_level} = '0;
        {periph_level, periph_vector, fetch_addr, data_addr, acc_instr_addr} = '0;
        {acc_branch_addr, dec_addr, dec_slot_target, trap_next_pc, status_word} = '0;
        {vector_base_register, stack_pointer} = '0;
        instr_boundary = 1;
        repeat (5) @(negedge clk);
        reset_n = 1;
        setup(0);
        {fetch_valid, fetch_addr, data_valid, data_size} = {1'b1, r & 32'hFFFFFFFE, 3'h6};
        data_addr = r & 32'hFFFFFFFC;
        none();
        setup(0);
        {data_valid, data_size, data_addr} = {3'h5, (r & 32'hFFFFFFFC) | 32'h2};
        none();
        setup(0);
        {fetch_valid, fetch_addr} = {1'b1, r | 32'h1};
        hit(8'h03, acc_instr_addr, 0, 0, 5);
        for (i = 1; i < 4; i++) begin
            setup(0);
            {data_valid, acc_in_slot, data_size} = {1'b1, i[0], (i == 1) ? 2'h1 : 2'h2};
            data_addr = (r & 32'hFFFFFFFC) | i;
            hit(8'h03, i[0] ? acc_branch_addr : acc_instr_addr, 0, 0, 0);
        end
        setup(0);
        {dec_valid, dec_opcode} = {1'b1, r[31:16] | 16'hFC00};
        hit(8'h01, dec_addr, 0, 0, 0);
        for (i = 0; i < 2; i++) begin
            setup(0);
            {dec_valid, dec_in_slot, dec_flow_change} = {2'h3, i[0]};
            dec_opcode = i[0] ? r[15:0] & 16'h7FFF : r[15:0] | 16'hFC00;
            hit(8'h02, dec_slot_target, 0, 0, 0);
        end
        setup(0);
        {fetch_valid, fetch_addr, trap_exec, dec_opcode} = {1'b1, r | 32'h1, 1'b1, 8'hC3, r[7:0]};
        hit(8'h03, acc_instr_addr, 0, 0, 0);
        hit(r[7:0], trap_next_pc, 0, 0, 0);
        setup(4'hF);
        nmi_pin = 1;
        hit(8'h0B, acc_instr_addr, 1, 4'hF, 0);
        setup(4'hF);
        break_controller_req = 1;
        none();
        for (i = 0; i < 2; i++) begin
            setup(4'hE);
            {break_controller_req, debug_interface_req} = i[0] ? 2'h1 : 2'h2;
            hit(8'(8'h0C + i), acc_instr_addr, 1, 4'hF, 0);
        end
        for (i = 0; i < 8; i++) begin
            setup(0);
            lv = r[3:0] | 4'h2;
            ext_level = ({28'h0, lv} << (i * 4)) | ({28'h0, lv - 4'h1} << (((i + 1) % 8) * 4));
            external_request_pins = (8'h1 << i) | (8'h1 << ((i + 1) % 8));
            hit((i < 4) ? 8'h40 + i : 8'h4C + i, acc_instr_addr, 1, lv, 0);
        end
        setup(4'h9);
        {ext_level, external_request_pins} = {32'h9, 8'h1};
        none();
        setup(4'h3);
        i = r[20:16] % 18;
        periph_req[i] = 1;
        periph_level[i*4 +: 4] = 4'h4;
        periph_vector[i*8 +: 8] = r[15:8];
        hit(r[15:8], acc_instr_addr, 1, 4'h4, 0);
        wrap_up();
    end

    initial begin
        #300us;
        fail_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
